// file: outport_pkg.sv
package outport_pkg;
   // printed offsets are register indices; byte address is four times these
   localparam logic [6:0] IDX_SET_A = 7'h10;
   localparam logic [6:0] IDX_CLEAR_A = 7'h11;
   localparam logic [6:0] IDX_SET_B = 7'h18;
   localparam logic [6:0] IDX_CLEAR_B = 7'h19;
   localparam logic [6:0] IDX_CFG_A = 7'h13;
   localparam logic [6:0] IDX_CFG_B = 7'h1B;
   localparam logic [6:0] IDX_RESERVED_LO = 7'h10;
   localparam logic [6:0] IDX_RESERVED_HI = 7'h7F;
   localparam int ADDR_W = 9;
   localparam int WORD_LSB = 2;
   localparam logic [1:0] CODE_OUTPUT = 2'h1;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] enable;
   } pin_drive_t;
endpackage

// file: output_port_set_clear.sv
`timescale 1ns/1ps
module output_port_set_clear (
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   input wire logic [outport_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [outport_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [7:0] PORT_A_OUT,
   output logic [7:0] PORT_A_OE,
   output logic [7:0] PORT_B_OUT,
   output logic [7:0] PORT_B_OE
);
   localparam int PINS = 8;

   logic aw_held_r;
   logic [6:0] aw_idx_r;
   logic w_held_r;
   logic [7:0] wbyte_r;
   logic wlane_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [7:0] latch_a_r;
   logic [7:0] latch_b_r;
   logic [15:0] cfg_a_r;
   logic [15:0] cfg_b_r;
   outport_pkg::pin_drive_t drive_a;
   outport_pkg::pin_drive_t drive_b;

   function automatic logic [7:0] route_en(input logic [15:0] cfg);
      logic [7:0] en;
      en = '0;
      for (int i = 0; i < PINS; i++) begin
         en[i] = (cfg[2*i +: 2] == outport_pkg::CODE_OUTPUT);
      end
      return en;
   endfunction

   // write channels are accepted in either order and held until both exist
   wire aw_take = S_AXI_AWVALID && !aw_held_r && !bvalid_r;
   wire w_take = S_AXI_WVALID && !w_held_r && !bvalid_r;
   wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
   localparam int WORD_LSB_C = outport_pkg::WORD_LSB;
   wire [6:0] aw_idx_in = S_AXI_AWADDR[outport_pkg::ADDR_W-1:WORD_LSB_C];
   wire wr_ok = wlane_r;
   wire hit_set_a = wr_fire && wr_ok
                    && aw_idx_r == outport_pkg::IDX_SET_A;
   wire hit_clr_a = wr_fire && wr_ok
                    && aw_idx_r == outport_pkg::IDX_CLEAR_A;
   wire hit_set_b = wr_fire && wr_ok
                    && aw_idx_r == outport_pkg::IDX_SET_B;
   wire hit_clr_b = wr_fire && wr_ok
                    && aw_idx_r == outport_pkg::IDX_CLEAR_B;
   wire hit_cfg_a = wr_fire && aw_idx_r == outport_pkg::IDX_CFG_A;
   wire hit_cfg_b = wr_fire && aw_idx_r == outport_pkg::IDX_CFG_B;
   wire wr_mapped = hit_set_a || hit_clr_a || hit_set_b || hit_clr_b
                    || hit_cfg_a || hit_cfg_b;

   // set wins over clear in the same byte is moot: one write per cycle
   wire [7:0] latch_a_nxt = hit_set_a ? (latch_a_r | wbyte_r)
                          : hit_clr_a ? (latch_a_r & ~wbyte_r)
                          : latch_a_r;
   wire [7:0] latch_b_nxt = hit_set_b ? (latch_b_r | wbyte_r)
                          : hit_clr_b ? (latch_b_r & ~wbyte_r)
                          : latch_b_r;
   // config pairs: two bits per pin, 16 bits per channel in low lanes
   logic [15:0] wdata_lo_r;
   wire [15:0] cfg_a_nxt = hit_cfg_a ? wdata_lo_r : cfg_a_r;
   wire [15:0] cfg_b_nxt = hit_cfg_b ? wdata_lo_r : cfg_b_r;

   // reads: set/clear words are write-only and return zero; latch hidden
   wire ar_take = S_AXI_ARVALID && !rvalid_r;
   wire [6:0] ar_idx = S_AXI_ARADDR[outport_pkg::ADDR_W-1:WORD_LSB_C];
   wire rd_cfg_a = ar_idx == outport_pkg::IDX_CFG_A;
   wire rd_cfg_b = ar_idx == outport_pkg::IDX_CFG_B;
   wire rd_wo = ar_idx == outport_pkg::IDX_SET_A
                || ar_idx == outport_pkg::IDX_CLEAR_A
                || ar_idx == outport_pkg::IDX_SET_B
                || ar_idx == outport_pkg::IDX_CLEAR_B;
   wire [31:0] rd_word = rd_cfg_a ? {16'h0000, cfg_a_r}
                       : rd_cfg_b ? {16'h0000, cfg_b_r}
                       : 32'h0000_0000;
   wire [1:0] rd_resp = (rd_cfg_a || rd_cfg_b || rd_wo)
                        ? outport_pkg::RESP_OKAY : outport_pkg::RESP_SLVERR;

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         aw_held_r <= 1'b0;
         aw_idx_r <= '0;
      end else if (aw_take) begin
         aw_held_r <= 1'b1;
         aw_idx_r <= aw_idx_in;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         w_held_r <= 1'b0;
         wbyte_r <= '0;
         wlane_r <= 1'b0;
         wdata_lo_r <= '0;
      end else if (w_take) begin
         w_held_r <= 1'b1;
         wbyte_r <= S_AXI_WDATA[7:0];
         wlane_r <= S_AXI_WSTRB[0];
         wdata_lo_r <= S_AXI_WDATA[15:0];
      end else if (wr_fire) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         bvalid_r <= 1'b0;
         bresp_r <= outport_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_mapped ? outport_pkg::RESP_OKAY
                              : outport_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= outport_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_resp;
      end else if (S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         latch_a_r <= outport_pkg::LATCH_RESET;
         latch_b_r <= outport_pkg::LATCH_RESET;
         cfg_a_r <= outport_pkg::CFG_RESET;
         cfg_b_r <= outport_pkg::CFG_RESET;
      end else begin
         latch_a_r <= latch_a_nxt;
         latch_b_r <= latch_b_nxt;
         cfg_a_r <= cfg_a_nxt;
         cfg_b_r <= cfg_b_nxt;
      end
   end

   assign drive_a.level = ~latch_a_r;
   assign drive_a.enable = route_en(cfg_a_r);
   assign drive_b.level = ~latch_b_r;
   assign drive_b.enable = route_en(cfg_b_r);

   assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
   assign S_AXI_WREADY = !w_held_r && !bvalid_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_ARREADY = !rvalid_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;
   assign PORT_A_OUT = drive_a.level;
   assign PORT_A_OE = drive_a.enable;
   assign PORT_B_OUT = drive_b.level;
   assign PORT_B_OE = drive_b.enable;

   logic seen_r;
   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         seen_r <= 1'b0;
      end else begin
         seen_r <= 1'b1;
      end
   end

   AST_CLEAR_A: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_clr_a |=> (latch_a_r & $past(wbyte_r)) == 8'h00)
      else $error("clear A left a bit set");
   AST_CLEAR_B: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_clr_b |=> (latch_b_r & $past(wbyte_r)) == 8'h00)
      else $error("clear B left a bit set");
   AST_CLEAR_KEEP: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_clr_b |=> (latch_b_r & ~$past(wbyte_r))
                    == ($past(latch_b_r) & ~$past(wbyte_r)))
      else $error("clear B changed an unselected bit");
   AST_CLEAR_KEEP_A: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_clr_a |=> (latch_a_r & ~$past(wbyte_r))
                    == ($past(latch_a_r) & ~$past(wbyte_r)))
      else $error("clear A changed an unselected bit");

   AST_CLEAR_ADDR: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_clr_b |-> aw_idx_r == 7'h19)
      else $error("clear B decoded at wrong index");
   AST_CLEAR_ADDR_A: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_clr_a |-> aw_idx_r == 7'h11)
      else $error("clear A decoded at wrong index");

   AST_INVERT: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      seen_r |-> (PORT_A_OUT ^ latch_a_r) == 8'hFF)
      else $error("pin level not inverse of latch");
   AST_INVERT_B: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      seen_r |-> (PORT_B_OUT ^ latch_b_r) == 8'hFF)
      else $error("pin level B not inverse of latch");
   AST_PIN_FOLLOWS: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_set_a |=> PORT_A_OUT == ~($past(latch_a_r) | $past(wbyte_r)))
      else $error("pins A did not follow a set write");

   AST_ROUTE: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      PORT_B_OE[0] == (cfg_b_r[1:0] == 2'h1))
      else $error("pin enable not tied to code 01");
   AST_ROUTE_A: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      PORT_A_OE[7] == (cfg_a_r[15:14] == 2'h1))
      else $error("pin A7 enable not tied to code 01");
   AST_ROUTE_OFF: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      cfg_b_r == outport_pkg::CFG_RESET |-> PORT_B_OE == 8'h00)
      else $error("pin B driven while no pin is an output");

   AST_HIDDEN: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      !hit_set_a && !hit_clr_a |=> latch_a_r == $past(latch_a_r))
      else $error("latch A changed without a write");
   AST_HIDDEN_B: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      !hit_set_b && !hit_clr_b |=> latch_b_r == $past(latch_b_r))
      else $error("latch B changed without a write");
   AST_NO_LEAK: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      ar_take && !rd_cfg_a && !rd_cfg_b |=> S_AXI_RDATA == 32'h0000_0000)
      else $error("read outside config returned data");
   AST_SET_REFUSED: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      wr_fire && !wlane_r && aw_idx_r == outport_pkg::IDX_SET_A
      |=> S_AXI_BRESP == outport_pkg::RESP_SLVERR
          && latch_a_r == $past(latch_a_r))
      else $error("set A took a write without its low byte lane");

   AST_SET_ADDR: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      ar_take && ar_idx == 7'h10 |=> S_AXI_RDATA == 32'h0000_0000)
      else $error("set register read returned data");
   AST_SET_ADDR_B: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      ar_take && ar_idx == 7'h18 |=> S_AXI_RDATA == 32'h0000_0000)
      else $error("set B register read returned data");

   AST_SET: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_set_b |=> (latch_b_r | ~$past(wbyte_r)) == 8'hFF)
      else $error("set B left a bit clear");
   AST_SET_A: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_set_a |=> (latch_a_r | ~$past(wbyte_r)) == 8'hFF)
      else $error("set A left a bit clear");
   AST_SET_KEEP_A: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_set_a |=> (latch_a_r & ~$past(wbyte_r))
                    == ($past(latch_a_r) & ~$past(wbyte_r)))
      else $error("set A changed an unselected bit");
   AST_SET_KEEP_B: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      hit_set_b |=> (latch_b_r & ~$past(wbyte_r))
                    == ($past(latch_b_r) & ~$past(wbyte_r)))
      else $error("set B changed an unselected bit");

   // one write at a time: a standing response blocks both write channels
   AST_ONE_WRITE: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write channel open while a response stands");
   AST_BRESP_LATE: assert property (@(posedge CLK_SYS)
      disable iff (!RESET_N)
      wr_fire |=> S_AXI_BVALID)
      else $error("write response missing one cycle after fire");
endmodule

// file: pin_pullup_model.sv
`timescale 1ns/1ps
// far side of the port: a released pin floats high on its pull-up,
// so a pin that is not driven reads high whatever level it last drove
module pin_pullup_model (
   input wire logic [7:0] drive,
   input wire logic [7:0] enable,
   output logic [7:0] level
);
   assign level = (drive & enable) | ~enable;
endmodule

// file: output_port_set_clear_tb_top.sv
`timescale 1ns/1ps
module output_port_set_clear_tb_top;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [8:0] awaddr = 9'h000;
   logic [8:0] araddr = 9'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [7:0] out_a, oe_a, out_b, oe_b, pin_a, pin_b;
   logic [7:0] la = 8'h00, lb = 8'h00;
   logic [15:0] ca = 16'h0000, cb = 16'h0000;
   logic [6:0] idx_tab [6] = '{outport_pkg::IDX_SET_A,
      outport_pkg::IDX_SET_B, outport_pkg::IDX_CLEAR_A,
      outport_pkg::IDX_CLEAR_B, outport_pkg::IDX_CFG_A, outport_pkg::IDX_CFG_B};
   int bad_count = 0, n_checks = 0, k, sel;
   always #10 clk = ~clk;
   output_port_set_clear dut (.CLK_SYS(clk), .RESET_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PORT_A_OUT(out_a),
      .PORT_A_OE(oe_a), .PORT_B_OUT(out_b), .PORT_B_OE(oe_b));
   pin_pullup_model pa (.drive(out_a), .enable(oe_a), .level(pin_a));
   pin_pullup_model pb (.drive(out_b), .enable(oe_b), .level(pin_b));
   task give_verdict;
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // per pin: enable when code is output, level inverse of latch bit when enabled, else high on the pull-up
   function automatic logic [15:0] pins(logic [7:0] l, logic [15:0] c);
      logic [15:0] v;
      for (int i = 0; i < 8; i++) begin
         v[i+8] = c[2*i+:2] == outport_pkg::CODE_OUTPUT;
         v[i] = v[i+8] ? ~l[i] : 1'h1;
      end
      return v;
   endfunction
   task check_ports;
      chk("port_a", 32'(pins(la, ca)), 32'({oe_a, pin_a}));
      chk("port_b", 32'(pins(lb, cb)), 32'({oe_b, pin_b}));
   endtask
   task wr(input logic [6:0] x, input logic [31:0] v, input logic [3:0] s);
      int i;
      awaddr <= {x, 2'h0};
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'h0;
      if (i == 50) begin
         bad_count++;
         give_verdict;
      end
      @(posedge clk);
   endtask
   task rd(input logic [6:0] x);
      int i;
      araddr <= {x, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      r = rresp;
      d = rdata;
      rready <= 1'h0;
      if (i == 50) begin
         bad_count++;
         give_verdict;
      end
      @(posedge clk);
   endtask
   initial begin
      k = $urandom(30113);
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      check_ports;
      for (k = 0; k < 60; k++) begin
         sel = (k < 6) ? k : $urandom % 6;
         d = $urandom;
         wr(idx_tab[sel], d, 4'hF);
         case (sel)
            0: la = la | d[7:0];
            1: lb = lb | d[7:0];
            2: la = la & ~d[7:0];
            3: lb = lb & ~d[7:0];
            4: ca = d[15:0];
            default: cb = d[15:0];
         endcase
         chk("bresp", 32'(outport_pkg::RESP_OKAY), 32'(r));
         check_ports;
      end
      // strobe without the low byte must leave the latch alone
      wr(outport_pkg::IDX_SET_A, 32'hFF, 4'hE);
      chk("bresp", 32'(outport_pkg::RESP_SLVERR), 32'(r));
      wr(7'h7F, 32'hFF, 4'hF);
      chk("bresp", 32'(outport_pkg::RESP_SLVERR), 32'(r));
      check_ports;
      for (k = 0; k < 4; k++) begin
         rd(idx_tab[k]);
         chk("rdata", 32'h0, d);
         chk("rresp", 32'(outport_pkg::RESP_OKAY), 32'(r));
      end
      rd(7'h20);
      chk("rresp", 32'(outport_pkg::RESP_SLVERR), 32'(r));
      rd(outport_pkg::IDX_CFG_A);
      chk("cfg_a", 32'(ca), d);
      rd(outport_pkg::IDX_CFG_B);
      chk("cfg_b", 32'(cb), d);
      chk("rresp", 32'(outport_pkg::RESP_OKAY), 32'(r));
      // reset in mid-run must drop both latches and release every pin
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      la = outport_pkg::LATCH_RESET;
      lb = outport_pkg::LATCH_RESET;
      ca = outport_pkg::CFG_RESET;
      cb = outport_pkg::CFG_RESET;
      @(posedge clk);
      check_ports;
      wr(outport_pkg::IDX_CFG_A, 32'h5555, 4'hF);
      ca = 16'h5555;
      wr(outport_pkg::IDX_SET_A, 32'hA5, 4'hF);
      la = la | 8'hA5;
      check_ports;
      give_verdict;
   end
endmodule
